/* serial_master.sv */
/*
 Paced serial master serving two slaves in turn with a busy handshake.
 Assumes busy and serial_data_in come from pins outside the clock
 domain, and that a slave pulls busy low when ready.
*/
// Overview of operation
// - Eight-bit characters, MSB first, type-1 phase
// - Serial clock gives one megabit per second
// - Character end pulse drives next character
// - Timers count clock divided by 128
// - One millisecond slot tick starts each step
// - Ten microsecond timeout on busy handshake
// - Slot tick selects slave, waits for busy
// - Busy timeout deselects slave, aborts sequence
// - Steps: status, transmit, exchange, receive
// - Status step sends command, reads one byte
// - Exchange data must equal complement of sent
// - Data mismatch halts all further communication
// - Sequence end toggles slave choice, restarts
// - Every operation opens with one command byte
// - Count is min of status and buffer
// - Status check command is all zeros
// - Receive command: top bits 01 plus count
// - Transmit command: top bits 10 plus count
// - Exchange command: top bits 11 plus count
// - After command, wait busy low again, timed
// - Chip select falling edge starts timeout
`timescale 1ns/1ps
`include "serial_master_cfg.svh"

module serial_master
	import serial_master_pkg::*;
#(
	parameter int SLOT_TICKS = `SLOT_TICKS,
	parameter int TIMEOUT_TICKS = `TIMEOUT_TICKS,
	parameter int BUF_SIZE = `BUF_SIZE
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Serial link pins
	output logic serial_clock_out,
	output logic serial_data_out,
	input wire logic serial_data_in,
	input wire logic busy,
	output logic cs1_n,
	output logic cs2_n,
	// Status and events
	output logic slave_choice_flag,
	output logic slot_tick_interrupt,
	output logic transfer_end_interrupt,
	output logic timeout_event,
	output logic halted,
	output logic [7:0] last_status
);

	// Pin synchronisers
	logic busy_meta_reg, busy_sync_reg;
	logic sdi_meta_reg, sdi_sync_reg;

	// Timers
	logic [6:0] pre_cnt_reg;
	logic [15:0] slot_cnt_reg;
	logic [7:0] to_cnt_reg;
	logic div_tick;

	// Sequencer state
	seq_state_t state_reg, state_next;
	step_t step_reg;
	logic [5:0] count_reg;
	logic [5:0] idx_reg;
	logic [7:0] seed_reg;
	logic abort_reg;
	logic inflight_reg;
	logic cs_act_reg;

	// Shifter handshake
	logic sh_start;
	logic sh_done;
	logic [7:0] sh_rx;
	logic [7:0] sh_tx;

	// Decodes
	logic timed_out;
	logic ready_seen;
	logic [5:0] n_bytes;
	logic last_byte;
	logic [7:0] cmd_byte;
	logic [7:0] pattern_now;
	logic mismatch;

	// Transmit data pattern for byte index of a sequence
	function automatic logic [7:0] pattern(input logic [7:0] seed, input logic [5:0] idx);
		pattern = seed + {2'b00, idx};
	endfunction

	// Smaller of reported count and local buffer
	function automatic logic [5:0] clamp_count(input logic [5:0] rep);
		clamp_count = (rep < 6'(BUF_SIZE)) ? rep : 6'(BUF_SIZE);
	endfunction

	// Two flip-flops before any logic reads a pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_meta_reg <= 1'b1;
			busy_sync_reg <= 1'b1;
			sdi_meta_reg <= 1'b1;
			sdi_sync_reg <= 1'b1;
		end else begin
			busy_meta_reg <= busy;
			busy_sync_reg <= busy_meta_reg;
			sdi_meta_reg <= serial_data_in;
			sdi_sync_reg <= sdi_meta_reg;
		end
	end

	// Divide by 128 for the timer tick
	assign div_tick = (pre_cnt_reg == 7'(`TICK_DIV - 1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt_reg <= 7'h00;
		end else begin
			pre_cnt_reg <= pre_cnt_reg + 7'h01;
		end
	end

	// Slot timer, free running; tick every millisecond
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_cnt_reg <= 16'h0000;
			slot_tick_interrupt <= 1'b0;
		end else begin
			slot_tick_interrupt <= 1'b0;
			if (div_tick) begin
				if (slot_cnt_reg == 16'(SLOT_TICKS - 1)) begin
					slot_cnt_reg <= 16'h0000;
					slot_tick_interrupt <= 1'b1;
				end else begin
					slot_cnt_reg <= slot_cnt_reg + 16'h0001;
				end
			end
		end
	end

	// Timeout timer; cleared on every state change, so it restarts at
	// the select edge and again after the command byte
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			to_cnt_reg <= 8'h00;
		end else if (state_next != state_reg) begin
			to_cnt_reg <= 8'h00;
		end else if (div_tick && !timed_out) begin
			to_cnt_reg <= to_cnt_reg + 8'h01;
		end
	end

	// Tick phase is not aligned to the select, so the real window is
	// up to one tick shorter than the nominal one
	assign timed_out = (to_cnt_reg >= 8'(TIMEOUT_TICKS));
	assign ready_seen = !busy_sync_reg;

	// Step decodes
	assign n_bytes = (step_reg == STEP_STATUS) ? 6'h01 : count_reg;
	assign last_byte = (idx_reg + 6'h01 >= n_bytes);
	assign pattern_now = pattern(seed_reg, idx_reg);

	// Command byte per step, count in the low six bits
	assign cmd_byte = (step_reg == STEP_STATUS) ? `CMD_STATUS :
		(step_reg == STEP_TX) ? {`CMD_TX_TOP, count_reg} :
		(step_reg == STEP_TRX) ? {`CMD_TRX_TOP, count_reg} :
		{`CMD_RX_TOP, count_reg};

	// Byte offered to the shifter; filler on receive-only steps
	assign sh_tx = (state_reg == ST_CMD) ? cmd_byte :
		(step_reg == STEP_TX || step_reg == STEP_TRX) ? pattern_now :
		`FILLER_BYTE;

	// Received data check on exchange and receive steps
	assign mismatch = (step_reg == STEP_TRX) ? (sh_rx != ~pattern_now) :
		(step_reg == STEP_RX) ? (sh_rx != pattern_now) : 1'b0;

	// One byte at a time; next one waits for the end pulse
	assign sh_start = (state_reg == ST_CMD || state_reg == ST_DATA) && !inflight_reg;

	// Sequencer next state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_WAIT_SLOT: begin
				if (slot_tick_interrupt) begin
					state_next = ST_SEL_WAIT;
				end
			end
			ST_SEL_WAIT: begin
				if (ready_seen) begin
					state_next = ST_CMD;
				end else if (timed_out) begin
					state_next = ST_END;
				end
			end
			ST_CMD: begin
				if (sh_done) begin
					state_next = ST_CMD_WAIT;
				end
			end
			ST_CMD_WAIT: begin
				if (ready_seen) begin
					state_next = (n_bytes == 6'h00) ? ST_END : ST_DATA;
				end else if (timed_out) begin
					state_next = ST_END;
				end
			end
			ST_DATA: begin
				if (sh_done && mismatch) begin
					state_next = ST_HALT;
				end else if (sh_done && last_byte) begin
					state_next = ST_END;
				end
			end
			ST_END: begin
				state_next = ST_WAIT_SLOT;
			end
			ST_HALT: begin
				state_next = ST_HALT;
			end
			default: begin
				state_next = ST_HALT;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_WAIT_SLOT;
		end else begin
			state_reg <= state_next;
		end
	end

	// Byte in flight flag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			inflight_reg <= 1'b0;
		end else if (sh_start) begin
			inflight_reg <= 1'b1;
		end else if (sh_done) begin
			inflight_reg <= 1'b0;
		end
	end

	// Byte index within a step
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idx_reg <= 6'h00;
		end else if (state_reg != ST_DATA) begin
			idx_reg <= 6'h00;
		end else if (sh_done) begin
			idx_reg <= idx_reg + 6'h01;
		end
	end

	// Status capture and data count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= 6'h00;
			last_status <= 8'h00;
		end else if (state_reg == ST_DATA && sh_done && step_reg == STEP_STATUS) begin
			last_status <= sh_rx;
			count_reg <= clamp_count(sh_rx[5:0]);
		end
	end

	// Abort mark for a timed-out handshake
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			abort_reg <= 1'b0;
			timeout_event <= 1'b0;
		end else begin
			timeout_event <= 1'b0;
			if ((state_reg == ST_SEL_WAIT || state_reg == ST_CMD_WAIT) && !ready_seen && timed_out) begin
				abort_reg <= 1'b1;
				timeout_event <= 1'b1;
			end else if (state_reg == ST_END) begin
				abort_reg <= 1'b0;
			end
		end
	end

	// Step order, slave switch and next data seed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			step_reg <= STEP_STATUS;
			slave_choice_flag <= 1'b0;
			seed_reg <= 8'h00;
		end else if (state_reg == ST_END) begin
			if (abort_reg || step_reg == STEP_RX) begin
				step_reg <= STEP_STATUS;
				slave_choice_flag <= !slave_choice_flag;
				if (!abort_reg) begin
					seed_reg <= seed_reg + 8'h01;
				end
			end else begin
				step_reg <= step_t'(step_reg + 2'b01);
			end
		end
	end

	// Chip select held from slot tick to step end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_act_reg <= 1'b0;
		end else if (state_next == ST_SEL_WAIT && state_reg == ST_WAIT_SLOT) begin
			cs_act_reg <= 1'b1;
		end else if (state_next == ST_END || state_next == ST_HALT) begin
			cs_act_reg <= 1'b0;
		end
	end

	// Select lines as flops so no glitch reaches the slave
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs1_n <= 1'b1;
			cs2_n <= 1'b1;
		end else begin
			cs1_n <= !(cs_act_reg && !slave_choice_flag);
			cs2_n <= !(cs_act_reg && slave_choice_flag);
		end
	end

	// Halt indicator
	assign halted = (state_reg == ST_HALT);

	// Shift engine; its done pulse is the transfer end event
	serial_shifter #(
		.HALF_CYC(`SCK_HALF_CYC)
	) u_shifter (
		.clk(clk),
		.rst_n(rst_n),
		.start(sh_start),
		.tx_byte(sh_tx),
		.done(sh_done),
		.rx_byte(sh_rx),
		.serial_in(sdi_sync_reg),
		.sck(serial_clock_out),
		.sdo(serial_data_out)
	);

	assign transfer_end_interrupt = sh_done;

endmodule

/* serial_master_cfg.svh */
/*
 Constants for the paced serial master: clock rates, timer counts,
 command codes and buffer size. Assumes a 40 MHz block clock.
*/
`ifndef SERIAL_MASTER_CFG_SVH
`define SERIAL_MASTER_CFG_SVH

// Clock and link rate
`define CLK_FREQ_KHZ 40000
`define BIT_RATE_KBPS 1000
`define SCK_HALF_CYC ((`CLK_FREQ_KHZ / `BIT_RATE_KBPS) / 2)

// Character format
`define CHAR_BITS 8

// Timer prescaler and tick counts
`define TICK_DIV 128
`define SLOT_US 1000
`define TIMEOUT_US 10
`define SLOT_TICKS ((`CLK_FREQ_KHZ * `SLOT_US) / (1000 * `TICK_DIV))
`define TIMEOUT_TICKS_RAW ((`CLK_FREQ_KHZ * `TIMEOUT_US) / (1000 * `TICK_DIV))
`define TIMEOUT_TICKS ((`TIMEOUT_TICKS_RAW < 1) ? 1 : `TIMEOUT_TICKS_RAW)

// Command codes and fields
`define CMD_STATUS 8'h00
`define CMD_RX_TOP 2'h1
`define CMD_TX_TOP 2'h2
`define CMD_TRX_TOP 2'h3
`define COUNT_W 6

// Local buffer size and filler
`define BUF_SIZE 8
`define FILLER_BYTE 8'hFF

`endif

/* serial_master_chk.sv */
/* Port checker for the paced serial master.
 Assumes one clock domain and the instance's slot count. */
`timescale 1ns/1ps
module serial_master_chk #(
	parameter int SLOT_TICKS = 312
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link and events
	input wire logic serial_clock_out,
	input wire logic serial_data_out,
	input wire logic serial_data_in,
	input wire logic busy,
	input wire logic cs1_n,
	input wire logic cs2_n,
	input wire logic slave_choice_flag,
	input wire logic slot_tick_interrupt,
	input wire logic transfer_end_interrupt,
	input wire logic timeout_event,
	input wire logic halted,
	input wire logic [7:0] last_status
);
	logic [15:0] slot_cnt;
	logic seen_tick;
	logic [5:0] low_cnt;
	logic [3:0] fall_cnt;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Counters: slot period, clock low time, falls per character
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_cnt <= 16'h0;
			seen_tick <= 1'b0;
			low_cnt <= 6'h0;
			fall_cnt <= 4'h0;
		end else begin
			slot_cnt <= slot_tick_interrupt ? 16'h0 : slot_cnt + 16'h1;
			seen_tick <= seen_tick | slot_tick_interrupt;
			low_cnt <= serial_clock_out ? 6'h0 : low_cnt + 6'h1;
			fall_cnt <= (transfer_end_interrupt ? 4'h0 : fall_cnt) + {3'h0, $fell(serial_clock_out)};
		end
	end
	sequence s_select;
		$fell(cs1_n) || $fell(cs2_n);
	endsequence
	sequence s_deselect;
		cs1_n && cs2_n;
	endsequence
	a_one_select: assert property (!(!cs1_n && !cs2_n)) else $error("both slaves selected");
	a_select_after_tick: assert property (s_select |-> $past(slot_tick_interrupt, 2)) else $error("select without tick");
	a_slave1_flag: assert property ($fell(cs1_n) |-> !slave_choice_flag) else $error("slave 1 wrong flag");
	a_slave2_flag: assert property ($fell(cs2_n) |-> slave_choice_flag) else $error("slave 2 wrong flag");
	a_slot_period: assert property (slot_tick_interrupt && seen_tick |-> slot_cnt == SLOT_TICKS * 128 - 1) else $error("slot period");
	a_sck_low_time: assert property ($rose(serial_clock_out) |-> low_cnt == 6'h14) else $error("clock low time");
	a_char_bits: assert property (transfer_end_interrupt |-> fall_cnt == 4'h8) else $error("bits per char");
	a_idle_clock: assert property (s_deselect |-> serial_clock_out) else $error("clock not idle");
	a_timeout_deselect: assert property (timeout_event |-> ##[0:2] s_deselect) else $error("timeout keeps select");
	a_timeout_busy: assert property (timeout_event |-> $past(busy, 3) && $past(busy, 5)) else $error("timeout while ready");
	a_halt_sticky: assert property (halted |=> halted && cs1_n && cs2_n) else $error("halt released");
endmodule
bind serial_master serial_master_chk #(.SLOT_TICKS(SLOT_TICKS)) chk (.clk(clk), .rst_n(rst_n),
	.serial_clock_out(serial_clock_out), .serial_data_out(serial_data_out), .serial_data_in(serial_data_in),
	.busy(busy), .cs1_n(cs1_n), .cs2_n(cs2_n), .slave_choice_flag(slave_choice_flag),
	.slot_tick_interrupt(slot_tick_interrupt), .transfer_end_interrupt(transfer_end_interrupt),
	.timeout_event(timeout_event), .halted(halted), .last_status(last_status));

/* serial_master_pkg.sv */
/*
 Types for the paced serial master: sequencer states and step codes.
 Assumes serial_master_cfg.svh carries the numeric constants.
*/
package serial_master_pkg;

	typedef enum logic [2:0] {
		ST_WAIT_SLOT = 3'b000,
		ST_SEL_WAIT = 3'b001,
		ST_CMD = 3'b010,
		ST_CMD_WAIT = 3'b011,
		ST_DATA = 3'b100,
		ST_END = 3'b101,
		ST_HALT = 3'b110
	} seq_state_t;

	typedef enum logic [1:0] {
		STEP_STATUS = 2'b00,
		STEP_TX = 2'b01,
		STEP_TRX = 2'b10,
		STEP_RX = 2'b11
	} step_t;

endpackage

/* serial_shifter.sv */
/*
 Eight-bit MSB-first shifter, type-1 phase: clock idles high, data
 changes on the falling edge, input sampled on the rising edge.
 Assumes serial_in is already synchronised to clk.
*/
`timescale 1ns/1ps
`include "serial_master_cfg.svh"

module serial_shifter #(
	parameter int HALF_CYC = `SCK_HALF_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Byte request
	input wire logic start,
	input wire logic [7:0] tx_byte,
	// Byte result
	output logic done,
	output logic [7:0] rx_byte,
	// Serial pins
	input wire logic serial_in,
	output logic sck,
	output logic sdo
);

	logic [7:0] half_reg;
	logic [2:0] bit_reg;
	logic [7:0] sh_reg;
	logic active_reg;
	logic half_end;

	assign half_end = (half_reg == 8'(HALF_CYC - 1));

	// Bit engine; low phase then high phase per bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			half_reg <= 8'h00;
			bit_reg <= 3'h0;
			sh_reg <= 8'h00;
			active_reg <= 1'b0;
			sck <= 1'b1;
			sdo <= 1'b1;
			done <= 1'b0;
			rx_byte <= 8'h00;
		end else begin
			done <= 1'b0;
			if (start && !active_reg) begin
				active_reg <= 1'b1;
				sh_reg <= tx_byte;
				sdo <= tx_byte[7];
				sck <= 1'b0;
				half_reg <= 8'h00;
				bit_reg <= 3'h0;
			end else if (active_reg) begin
				half_reg <= half_end ? 8'h00 : half_reg + 8'h01;
				if (half_end && !sck) begin
					sck <= 1'b1;
					sh_reg <= {sh_reg[6:0], serial_in};
				end else if (half_end && sck) begin
					if (bit_reg == 3'h7) begin
						active_reg <= 1'b0;
						done <= 1'b1;
						rx_byte <= sh_reg;
					end else begin
						sck <= 1'b0;
						sdo <= sh_reg[7];
						bit_reg <= bit_reg + 3'h1;
					end
				end
			end
		end
	end

endmodule

/* slave_model.sv */
/* Behavioural slave pair behind shared busy and data lines.
 Assumes the bench clock is the master's clock. */
`timescale 1ns/1ps
module slave_model (
	// Clock, reset, scenario controls
	input wire logic clk,
	input wire logic rst_n,
	input wire logic mute,
	input wire logic corrupt,
	input wire logic [5:0] avail,
	// Link pins
	input wire logic sck,
	input wire logic mosi,
	input wire logic cs1_n,
	input wire logic cs2_n,
	output logic busy,
	output logic miso,
	// Observation
	output logic cmd_seen,
	output logic [7:0] cmd,
	output logic bad_fill,
	output logic early_clk
);
	logic sck_q;
	logic first;
	logic [7:0] rx_sh;
	logic [7:0] tx_sh;
	logic [7:0] b;
	logic [7:0] store [8];
	logic [2:0] bitc;
	logic [2:0] idx;
	logic [2:0] ni;
	logic [5:0] rdy;
	wire sel = !(cs1_n && cs2_n);
	// Released line pulls high; a muted slave never gets ready
	// Busy again after every command, so a master that skips the second wait is caught
	assign busy = !sel || mute || rdy < 6'h30;
	// Byte completing at this rising edge, and index of the next reply
	assign b = {rx_sh[6:0], mosi};
	assign ni = first ? 3'h0 : idx + 3'h1;
	// Shift on link clock edges, reply chosen from the command
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_q <= 1'b1;
			rdy <= 6'h00;
			miso <= 1'b1;
			tx_sh <= 8'hFF;
			early_clk <= 1'b0;
			cmd_seen <= 1'b0;
			bad_fill <= 1'b0;
		end else begin
			sck_q <= sck;
			cmd_seen <= 1'b0;
			if (!sel) begin
				rdy <= 6'h00;
				bitc <= 3'h0;
				idx <= 3'h0;
				first <= 1'b1;
				tx_sh <= 8'hFF; // No unknown reply bits in the command byte
				miso <= ~miso; // Unselected output is not held
			end else begin
				if (rdy != 6'h3F) rdy <= rdy + 6'h01;
				if (sck_q && !sck) begin
					miso <= tx_sh[7];
					tx_sh <= tx_sh << 1;
					if (busy) early_clk <= 1'b1;
				end
				if (!sck_q && sck) begin
					rx_sh <= b;
					bitc <= bitc + 3'h1;
					if (bitc == 3'h7) begin
						idx <= ni;
						first <= 1'b0;
						if (first) begin
							cmd <= b;
							cmd_seen <= 1'b1;
							rdy <= 6'h00;
						end else if (cmd[7]) store[idx] <= b;
						else if (b != 8'hFF) bad_fill <= 1'b1;
						case (first ? b[7:6] : cmd[7:6])
							2'h0: tx_sh <= {2'h1, avail};
							2'h1: tx_sh <= store[ni];
							2'h3: tx_sh <= ~store[ni] ^ {7'h0, corrupt};
							default: tx_sh <= 8'h00;
						endcase
					end
				end
			end
		end
	end
endmodule

/* test_serial_master.sv */
/* Self-checking bench for the paced serial master.
 Assumes slave_model stands on the link pins. */
`timescale 1ns/1ps
module test_serial_master;
	logic clk = 1'b0;
	logic rst_n;
	logic mute = 1'b0;
	logic corrupt = 1'b0;
	logic [5:0] avail = 6'h0;
	logic busy, miso, sck, sdo, cs1_n, cs2_n, flag, tick, tend, tev, halted, cmd_seen, bad_fill, early_clk;
	logic [7:0] last_status;
	logic [7:0] cmd;
	logic [7:0] cmds [$];
	int fails = 0;
	int check_count = 0;
	always #12.5 clk = ~clk;
	serial_master #(.SLOT_TICKS(12)) DUT (.clk(clk), .rst_n(rst_n), .serial_clock_out(sck),
		.serial_data_out(sdo), .serial_data_in(miso), .busy(busy), .cs1_n(cs1_n), .cs2_n(cs2_n),
		.slave_choice_flag(flag), .slot_tick_interrupt(tick), .transfer_end_interrupt(tend),
		.timeout_event(tev), .halted(halted), .last_status(last_status));
	slave_model partner (.clk(clk), .rst_n(rst_n), .mute(mute), .corrupt(corrupt), .avail(avail),
		.sck(sck), .mosi(sdo), .cs1_n(cs1_n), .cs2_n(cs2_n), .busy(busy), .miso(miso),
		.cmd_seen(cmd_seen), .cmd(cmd), .bad_fill(bad_fill), .early_clk(early_clk));
	// Log every command byte the slave sees
	always @(posedge clk) if (cmd_seen === 1'b1) cmds.push_back(cmd);
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		if (fails == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// One whole sequence with a given status count
	task automatic run_seq(input logic [5:0] n, input logic [5:0] clip);
		logic f;
		int i;
		f = flag;
		@(posedge clk) avail <= n;
		cmds.delete();
		for (i = 0; i < 30000 && cmds.size() < 4; i++) @(posedge clk);
		for (i = 0; i < 6000 && !(cs1_n && cs2_n); i++) @(posedge clk);
		repeat (4) @(posedge clk);
		check(8'(cmds.size()), 8'h04);
		check(cmds[0], 8'h00);
		check(cmds[1], {2'h2, clip});
		check(cmds[2], {2'h3, clip});
		check(cmds[3], {2'h1, clip});
		check(last_status, {2'h1, n});
		check({7'h0, halted}, 8'h00);
		check({7'h0, bad_fill}, 8'h00);
		check({7'h0, early_clk}, 8'h00);
		check({7'h0, flag}, {7'h0, ~f});
	endtask
	// Slave never ready: abort and switch
	task automatic t_timeout();
		logic f;
		int i;
		f = flag;
		@(posedge clk) mute <= 1'b1;
		for (i = 0; i < 8000 && tev !== 1'b1; i++) @(posedge clk);
		check({7'h0, tev}, 8'h01);
		repeat (4) @(posedge clk);
		check({6'h0, cs1_n, cs2_n}, 8'h03);
		check({7'h0, flag}, {7'h0, ~f});
		mute <= 1'b0;
	endtask
	// Wrong exchange reply halts everything
	task automatic t_mismatch();
		int i;
		@(posedge clk) corrupt <= 1'b1;
		avail <= 6'h02;
		for (i = 0; i < 20000 && halted !== 1'b1; i++) @(posedge clk);
		check({7'h0, halted}, 8'h01);
		cmds.delete();
		repeat (4000) @(posedge clk);
		check(8'(cmds.size()), 8'h00);
		check({7'h0, halted}, 8'h01);
	endtask
	// Watchdog sized well past the whole run
	initial begin
		repeat (90000) @(posedge clk);
		fails++;
		$display("CHECK FAILED %0t watchdog expired", $time);
		report_and_stop();
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		check({5'h0, cs1_n, cs2_n, sck}, 8'h07);
		run_seq(6'h03, 6'h03);
		run_seq(6'h3F, 6'h08);
		t_timeout();
		run_seq(6'h00, 6'h00);
		t_mismatch();
		report_and_stop();
	end
endmodule
